// >>> spk_pkg.sv
// register map, field positions and reset values of the speaker path control bank
`default_nettype none
package spk_pkg;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;

	// register offsets
	localparam logic [6:0] OFS_REF_CTRL = 7'h04;
	localparam logic [6:0] OFS_MIXER    = 7'h07;
	localparam logic [6:0] OFS_POP      = 7'h08;
	localparam logic [6:0] OFS_BOOST    = 7'h09;
	localparam logic [6:0] OFS_CLASS    = 7'h0A;
	localparam logic [6:0] OFS_POWER    = 7'h0B;

	// reference control
	localparam int BIT_REF_BUF_EN = 5;

	// analogue input mixer
	localparam int BIT_CONV_PATH_EN = 4;
	localparam int BIT_IN_B_ATTEN   = 3;
	localparam int BIT_IN_B_PATH_EN = 2;
	localparam int BIT_IN_A_ATTEN   = 1;
	localparam int BIT_IN_A_PATH_EN = 0;

	// output pop suppression
	localparam int BIT_LINE_DISCHARGE = 2;
	localparam int BIT_CLAMP_RES_SEL  = 1;
	localparam int BIT_LINE_CLAMP     = 0;

	// speaker boost gain
	localparam int DC_BOOST_LSB = 3;
	localparam int AC_BOOST_LSB = 0;
	localparam int BOOST_W      = 3;
	localparam logic [2:0] BOOST_RESET   = 3'h3;
	localparam logic [2:0] BOOST_MAX     = 3'h5;
	localparam logic [2:0] BOOST_UNITY   = 3'h0;

	// speaker class select
	localparam int BIT_CLASS_SEL = 6;
	localparam int BIT_POP_A     = 4;
	localparam int BIT_POP_B     = 3;

	// power and thermal
	localparam int BIT_THERM_SHUT_EN = 8;
	localparam int BIT_THERM_SENS_EN = 7;
	localparam int BIT_TEMP_STATUS   = 6;
	localparam int BIT_LINE_OUT_EN   = 4;
	localparam int BIT_SPK_GAIN_EN   = 2;
	localparam int BIT_SPK_OUT_EN    = 1;
	localparam int BIT_CONV_EN       = 0;

	// class select encoding
	localparam logic CLASS_SWITCHING = 1'b0;
	localparam logic CLASS_LINEAR    = 1'b1;

	// reset values of single-bit controls and the zero read word
	localparam logic POP_RESET      = 1'b1;
	localparam logic THERM_RESET    = 1'b1;
	localparam logic CTRL_OFF_RESET = 1'b0;
	localparam logic [15:0] RD_ZERO = 16'h0000;

endpackage
`default_nettype wire

// >>> spk_path_regs.sv
// speaker path control register bank with derived analogue control levels
`timescale 1ns/10ps
`default_nettype none

module spk_path_regs #(
	parameter int ADDR_W = spk_pkg::ADDR_W,
	parameter int DATA_W = spk_pkg::DATA_W
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              reg_wr_en,
	input  wire logic              reg_rd_en,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wr_data,
	output var  logic [DATA_W-1:0] reg_rd_data,
	output var  logic              reg_rd_valid,
	input  wire logic              over_temp,
	output var  logic              reference_buffer_en,
	output var  logic              converter_path_en,
	output var  logic              input_a_path_en,
	output var  logic              input_b_path_en,
	output var  logic              input_a_atten,
	output var  logic              input_b_atten,
	output var  logic              line_output_discharge,
	output var  logic              line_clamp_active,
	output var  logic              clamp_res_low,
	output var  logic [2:0]        speaker_dc_boost,
	output var  logic [2:0]        speaker_ac_boost,
	output var  logic              speaker_class_sel,
	output var  logic              pop_suppress_a,
	output var  logic              pop_suppress_b,
	output var  logic              thermal_sensor_en,
	output var  logic              temp_status,
	output var  logic              thermal_trip,
	output var  logic              line_output_en,
	output var  logic              speaker_gain_stage_en,
	output var  logic              speaker_output_en,
	output var  logic              converter_en
);

	// programmed register state
	logic       ref_buf_r;
	logic       conv_path_r;
	logic       in_a_en_r;
	logic       in_b_en_r;
	logic       in_a_att_r;
	logic       in_b_att_r;
	logic       discharge_r;
	logic       clamp_res_r;
	logic       clamp_r;
	logic [2:0] dc_boost_r;
	logic [2:0] ac_boost_r;
	logic       class_r;
	logic       pop_a_r;
	logic       pop_b_r;
	logic       shut_en_r;
	logic       sens_en_r;
	logic       line_en_r;
	logic       gain_en_r;
	logic       spk_en_r;
	logic       conv_en_r;

	logic       temp_nxt;
	logic       trip_nxt;
	logic       wr_ref;
	logic       wr_mix;
	logic       wr_pop;
	logic       wr_boost;
	logic       wr_class;
	logic       wr_power;
	logic [DATA_W-1:0] rd_nxt;

	// reserved boost codes fall back to unity so an illegal write never raises gain
	function automatic logic [2:0] boost_code(input logic [2:0] code);
		if (code > spk_pkg::BOOST_MAX) begin
			boost_code = spk_pkg::BOOST_UNITY;
		end else begin
			boost_code = code;
		end
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [6:0] ofs);
		hit = (a == ADDR_W'(ofs));
	endfunction

	function automatic logic [DATA_W-1:0] zero_word();
		zero_word = DATA_W'(spk_pkg::RD_ZERO);
	endfunction

	assign wr_ref   = reg_wr_en && hit(reg_addr, spk_pkg::OFS_REF_CTRL);
	assign wr_mix   = reg_wr_en && hit(reg_addr, spk_pkg::OFS_MIXER);
	assign wr_pop   = reg_wr_en && hit(reg_addr, spk_pkg::OFS_POP);
	assign wr_boost = reg_wr_en && hit(reg_addr, spk_pkg::OFS_BOOST);
	assign wr_class = reg_wr_en && hit(reg_addr, spk_pkg::OFS_CLASS);
	assign wr_power = reg_wr_en && hit(reg_addr, spk_pkg::OFS_POWER);

	// reference control
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ref_buf_r <= spk_pkg::CTRL_OFF_RESET;
		end else if (wr_ref) begin
			ref_buf_r <= reg_wr_data[spk_pkg::BIT_REF_BUF_EN];
		end
	end

	// input mixer
	always_ff @(posedge core_clk) begin
		if (reset) begin
			conv_path_r <= spk_pkg::CTRL_OFF_RESET;
			in_a_en_r   <= spk_pkg::CTRL_OFF_RESET;
			in_b_en_r   <= spk_pkg::CTRL_OFF_RESET;
			in_a_att_r  <= spk_pkg::CTRL_OFF_RESET;
			in_b_att_r  <= spk_pkg::CTRL_OFF_RESET;
		end else if (wr_mix) begin
			conv_path_r <= reg_wr_data[spk_pkg::BIT_CONV_PATH_EN];
			in_a_en_r   <= reg_wr_data[spk_pkg::BIT_IN_A_PATH_EN];
			in_b_en_r   <= reg_wr_data[spk_pkg::BIT_IN_B_PATH_EN];
			in_a_att_r  <= reg_wr_data[spk_pkg::BIT_IN_A_ATTEN];
			in_b_att_r  <= reg_wr_data[spk_pkg::BIT_IN_B_ATTEN];
		end
	end

	// line output anti-pop
	always_ff @(posedge core_clk) begin
		if (reset) begin
			discharge_r <= spk_pkg::CTRL_OFF_RESET;
			clamp_res_r <= spk_pkg::CTRL_OFF_RESET;
			clamp_r     <= spk_pkg::CTRL_OFF_RESET;
		end else if (wr_pop) begin
			discharge_r <= reg_wr_data[spk_pkg::BIT_LINE_DISCHARGE];
			clamp_res_r <= reg_wr_data[spk_pkg::BIT_CLAMP_RES_SEL];
			clamp_r     <= reg_wr_data[spk_pkg::BIT_LINE_CLAMP];
		end
	end

	// speaker boost; raw codes are stored so reads return what was written
	always_ff @(posedge core_clk) begin
		if (reset) begin
			dc_boost_r <= spk_pkg::BOOST_RESET;
			ac_boost_r <= spk_pkg::BOOST_RESET;
		end else if (wr_boost) begin
			dc_boost_r <= reg_wr_data[spk_pkg::DC_BOOST_LSB +: spk_pkg::BOOST_W];
			ac_boost_r <= reg_wr_data[spk_pkg::AC_BOOST_LSB +: spk_pkg::BOOST_W];
		end
	end

	// speaker class and pop suppression bits
	always_ff @(posedge core_clk) begin
		if (reset) begin
			class_r <= spk_pkg::CLASS_SWITCHING;
			pop_a_r <= spk_pkg::POP_RESET;
			pop_b_r <= spk_pkg::POP_RESET;
		end else if (wr_class) begin
			class_r <= reg_wr_data[spk_pkg::BIT_CLASS_SEL];
			pop_a_r <= reg_wr_data[spk_pkg::BIT_POP_A];
			pop_b_r <= reg_wr_data[spk_pkg::BIT_POP_B];
		end
	end

	// power and thermal; the status bit has no storage so writes cannot touch it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			shut_en_r <= spk_pkg::THERM_RESET;
			sens_en_r <= spk_pkg::THERM_RESET;
			line_en_r <= spk_pkg::CTRL_OFF_RESET;
			gain_en_r <= spk_pkg::CTRL_OFF_RESET;
			spk_en_r  <= spk_pkg::CTRL_OFF_RESET;
			conv_en_r <= spk_pkg::CTRL_OFF_RESET;
		end else if (wr_power) begin
			shut_en_r <= reg_wr_data[spk_pkg::BIT_THERM_SHUT_EN];
			sens_en_r <= reg_wr_data[spk_pkg::BIT_THERM_SENS_EN];
			line_en_r <= reg_wr_data[spk_pkg::BIT_LINE_OUT_EN];
			gain_en_r <= reg_wr_data[spk_pkg::BIT_SPK_GAIN_EN];
			spk_en_r  <= reg_wr_data[spk_pkg::BIT_SPK_OUT_EN];
			conv_en_r <= reg_wr_data[spk_pkg::BIT_CONV_EN];
		end
	end

	// a disabled sensor reports nothing, so status and trip both need it
	assign temp_nxt = sens_en_r & over_temp;
	assign trip_nxt = shut_en_r & temp_nxt;

	// read mux; unmapped offsets and unlisted bits read zero
	always_comb begin
		rd_nxt = zero_word();
		case (reg_addr)
			ADDR_W'(spk_pkg::OFS_REF_CTRL): begin
				rd_nxt[spk_pkg::BIT_REF_BUF_EN] = ref_buf_r;
			end
			ADDR_W'(spk_pkg::OFS_MIXER): begin
				rd_nxt[spk_pkg::BIT_CONV_PATH_EN] = conv_path_r;
				rd_nxt[spk_pkg::BIT_IN_B_ATTEN]   = in_b_att_r;
				rd_nxt[spk_pkg::BIT_IN_B_PATH_EN] = in_b_en_r;
				rd_nxt[spk_pkg::BIT_IN_A_ATTEN]   = in_a_att_r;
				rd_nxt[spk_pkg::BIT_IN_A_PATH_EN] = in_a_en_r;
			end
			ADDR_W'(spk_pkg::OFS_POP): begin
				rd_nxt[spk_pkg::BIT_LINE_DISCHARGE] = discharge_r;
				rd_nxt[spk_pkg::BIT_CLAMP_RES_SEL]  = clamp_res_r;
				rd_nxt[spk_pkg::BIT_LINE_CLAMP]     = clamp_r;
			end
			ADDR_W'(spk_pkg::OFS_BOOST): begin
				rd_nxt[spk_pkg::DC_BOOST_LSB +: spk_pkg::BOOST_W] = dc_boost_r;
				rd_nxt[spk_pkg::AC_BOOST_LSB +: spk_pkg::BOOST_W] = ac_boost_r;
			end
			ADDR_W'(spk_pkg::OFS_CLASS): begin
				rd_nxt[spk_pkg::BIT_CLASS_SEL] = class_r;
				rd_nxt[spk_pkg::BIT_POP_A]     = pop_a_r;
				rd_nxt[spk_pkg::BIT_POP_B]     = pop_b_r;
			end
			ADDR_W'(spk_pkg::OFS_POWER): begin
				rd_nxt[spk_pkg::BIT_THERM_SHUT_EN] = shut_en_r;
				rd_nxt[spk_pkg::BIT_THERM_SENS_EN] = sens_en_r;
				rd_nxt[spk_pkg::BIT_TEMP_STATUS]   = temp_nxt;
				rd_nxt[spk_pkg::BIT_LINE_OUT_EN]   = line_en_r;
				rd_nxt[spk_pkg::BIT_SPK_GAIN_EN]   = gain_en_r;
				rd_nxt[spk_pkg::BIT_SPK_OUT_EN]    = spk_en_r;
				rd_nxt[spk_pkg::BIT_CONV_EN]       = conv_en_r;
			end
			default: begin
				rd_nxt = zero_word();
			end
		endcase
	end

	// read port
	always_ff @(posedge core_clk) begin
		if (reset) begin
			reg_rd_data  <= zero_word();
			reg_rd_valid <= spk_pkg::CTRL_OFF_RESET;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rd_data <= rd_nxt;
			end
		end
	end

	// plain control levels
	always_ff @(posedge core_clk) begin
		if (reset) begin
			reference_buffer_en <= spk_pkg::CTRL_OFF_RESET;
			converter_path_en   <= spk_pkg::CTRL_OFF_RESET;
			input_a_path_en     <= spk_pkg::CTRL_OFF_RESET;
			input_b_path_en     <= spk_pkg::CTRL_OFF_RESET;
			input_a_atten       <= spk_pkg::CTRL_OFF_RESET;
			input_b_atten       <= spk_pkg::CTRL_OFF_RESET;
			line_output_discharge <= spk_pkg::CTRL_OFF_RESET;
			speaker_class_sel   <= spk_pkg::CLASS_SWITCHING;
			thermal_sensor_en   <= spk_pkg::THERM_RESET;
			converter_en        <= spk_pkg::CTRL_OFF_RESET;
			speaker_gain_stage_en <= spk_pkg::CTRL_OFF_RESET;
		end else begin
			reference_buffer_en <= ref_buf_r;
			converter_path_en   <= conv_path_r;
			input_a_path_en     <= in_a_en_r;
			input_b_path_en     <= in_b_en_r;
			input_a_atten       <= in_a_att_r;
			input_b_atten       <= in_b_att_r;
			line_output_discharge <= discharge_r;
			speaker_class_sel   <= class_r;
			thermal_sensor_en   <= sens_en_r;
			converter_en        <= conv_en_r;
			speaker_gain_stage_en <= gain_en_r;
		end
	end

	// line clamp qualification; the clamp is meaningless without the buffered reference
	always_ff @(posedge core_clk) begin
		if (reset) begin
			line_clamp_active <= spk_pkg::CTRL_OFF_RESET;
			clamp_res_low     <= spk_pkg::CTRL_OFF_RESET;
		end else begin
			line_clamp_active <= clamp_r & ~line_en_r & ref_buf_r;
			clamp_res_low     <= clamp_res_r & ~line_en_r & clamp_r;
		end
	end

	// boost codes as applied to the amplifier
	always_ff @(posedge core_clk) begin
		if (reset) begin
			speaker_dc_boost <= spk_pkg::BOOST_RESET;
			speaker_ac_boost <= spk_pkg::BOOST_RESET;
		end else begin
			speaker_dc_boost <= boost_code(dc_boost_r);
			speaker_ac_boost <= boost_code(ac_boost_r);
		end
	end

	// pop suppression: automatic in switching mode, register driven in linear mode
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pop_suppress_a <= spk_pkg::POP_RESET;
			pop_suppress_b <= spk_pkg::POP_RESET;
		end else if (class_r == spk_pkg::CLASS_SWITCHING) begin
			pop_suppress_a <= ~spk_en_r;
			pop_suppress_b <= ~spk_en_r;
		end else begin
			pop_suppress_a <= pop_a_r;
			pop_suppress_b <= pop_b_r;
		end
	end

	// thermal status and gated output enables
	always_ff @(posedge core_clk) begin
		if (reset) begin
			temp_status       <= spk_pkg::CTRL_OFF_RESET;
			thermal_trip      <= spk_pkg::CTRL_OFF_RESET;
			line_output_en    <= spk_pkg::CTRL_OFF_RESET;
			speaker_output_en <= spk_pkg::CTRL_OFF_RESET;
		end else begin
			temp_status       <= temp_nxt;
			thermal_trip      <= trip_nxt;
			line_output_en    <= line_en_r & ~trip_nxt;
			speaker_output_en <= spk_en_r & ~trip_nxt;
		end
	end

endmodule

`default_nettype wire

// >>> spk_checker.sv
// bound assertions for the speaker path control bank
`timescale 1ns/10ps
`default_nettype none
module spk_checker (
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       reg_rd_en,
	input wire logic       reg_rd_valid,
	input wire logic       over_temp,
	input wire logic       thermal_sensor_en,
	input wire logic       temp_status,
	input wire logic       thermal_trip,
	input wire logic       speaker_class_sel,
	input wire logic       speaker_output_en,
	input wire logic       line_output_en,
	input wire logic       reference_buffer_en,
	input wire logic       pop_suppress_a,
	input wire logic       pop_suppress_b,
	input wire logic       line_clamp_active,
	input wire logic       clamp_res_low,
	input wire logic [2:0] speaker_dc_boost,
	input wire logic [2:0] speaker_ac_boost
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_hot;
		over_temp ##1 thermal_sensor_en;
	endsequence
	property p_rdv;
		reg_rd_en |=> reg_rd_valid;
	endproperty
	a_rdv: assert property (p_rdv) else $error("read answer late");
	property p_status;
		s_hot |-> temp_status;
	endproperty
	a_status: assert property (p_status) else $error("status missed heat");
	property p_cause;
		temp_status |-> $past(over_temp);
	endproperty
	a_cause: assert property (p_cause) else $error("status without heat");
	property p_trip;
		thermal_trip |-> !line_output_en && !speaker_output_en;
	endproperty
	a_trip: assert property (p_trip) else $error("outputs live in trip");
	// trip gates the speaker enable but not the pop logic, so leave it out
	property p_popd;
		!speaker_class_sel && !thermal_trip |-> {pop_suppress_a, pop_suppress_b} == {2{!speaker_output_en}};
	endproperty
	a_popd: assert property (p_popd) else $error("pop not following enable");
	property p_clamp;
		line_clamp_active |-> !line_output_en && reference_buffer_en;
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp with line on");
	property p_res;
		clamp_res_low |-> !line_output_en;
	endproperty
	a_res: assert property (p_res) else $error("low res with line on");
	property p_dc;
		speaker_dc_boost <= 3'h5;
	endproperty
	a_dc: assert property (p_dc) else $error("dc boost reserved");
	property p_ac;
		speaker_ac_boost <= 3'h5;
	endproperty
	a_ac: assert property (p_ac) else $error("ac boost reserved");
	property p_rst;
		disable iff (1'b0) reset |=> pop_suppress_a && pop_suppress_b && thermal_sensor_en;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset levels");
endmodule
bind spk_path_regs spk_checker spk_checker_i (
	.core_clk, .reset, .reg_rd_en, .reg_rd_valid, .over_temp, .thermal_sensor_en, .temp_status,
	.thermal_trip, .speaker_class_sel, .speaker_output_en, .line_output_en, .reference_buffer_en, .pop_suppress_a,
	.pop_suppress_b, .line_clamp_active, .clamp_res_low, .speaker_dc_boost, .speaker_ac_boost
);
`default_nettype wire

// >>> spk_host.sv
// host model driving the register strobe port
`timescale 1ns/10ps
`default_nettype none
module spk_host (
	input  wire logic        core_clk,
	input  wire logic [15:0] reg_rd_data,
	input  wire logic        reg_rd_valid,
	output var  logic        reg_wr_en,
	output var  logic        reg_rd_en,
	output var  logic [6:0]  reg_addr,
	output var  logic [15:0] reg_wr_data
);
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 7'h00;
		reg_wr_data = 16'h0000;
	end
	// idle lines invert so a stale value never passes for a live one
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge core_clk);
		#1;
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wr_data = d;
		@(posedge core_clk);
		#1;
		reg_wr_en = 1'b0;
		reg_addr = ~a;
		reg_wr_data = ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic late);
		@(posedge core_clk);
		#1;
		reg_rd_en = 1'b1;
		reg_addr = a;
		@(posedge core_clk);
		#1;
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		late = reg_rd_valid !== 1'b1;
		d = reg_rd_data;
	endtask
endmodule
`default_nettype wire

// >>> spk_path_regs_test.sv
// self-checking bench for the speaker path control bank
`timescale 1ns/10ps
`default_nettype none
module spk_path_regs_test;
	logic        core_clk;
	logic        reset;
	logic        over_temp;
	logic        reg_wr_en;
	logic        reg_rd_en;
	logic [6:0]  reg_addr;
	logic [15:0] reg_wr_data;
	logic [15:0] reg_rd_data;
	logic        reg_rd_valid;
	logic [18:0] o;
	logic [2:0]  dc;
	logic [2:0]  ac;
	int          n_mismatch;
	int          cmp_count;
	logic [6:0]  adr [7] = '{7'h04, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h05};
	logic [15:0] rst_v [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h001B, 16'h0018, 16'h0180, 16'h0000};
	logic [15:0] all_v [7] = '{16'h0020, 16'h001F, 16'h0007, 16'h003F, 16'h0058, 16'h0197, 16'h0000};
	spk_path_regs spk_path_regs_i (
		.core_clk, .reset, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
		.reg_rd_valid, .over_temp, .reference_buffer_en(o[0]), .converter_path_en(o[1]),
		.input_a_path_en(o[2]), .input_b_path_en(o[3]), .input_a_atten(o[4]), .input_b_atten(o[5]),
		.line_output_discharge(o[6]), .line_clamp_active(o[7]), .clamp_res_low(o[8]),
		.speaker_class_sel(o[9]), .pop_suppress_a(o[10]), .pop_suppress_b(o[11]),
		.thermal_sensor_en(o[12]), .temp_status(o[13]), .thermal_trip(o[14]), .line_output_en(o[15]),
		.speaker_gain_stage_en(o[16]), .speaker_output_en(o[17]), .converter_en(o[18]),
		.speaker_dc_boost(dc), .speaker_ac_boost(ac)
	);
	spk_host spk_host_i (.core_clk, .reg_rd_data, .reg_rd_valid, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data);
	task automatic conclude();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [18:0] seen, input logic [18:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic        late;
		spk_host_i.rd(a, d, late);
		if (late) begin
			n_mismatch++;
			conclude();
		end
		chk("read", {3'h0, d}, {3'h0, e});
	endtask
	// derived levels show one edge after the write is taken; settle waits two edges
	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task automatic ws(input logic [6:0] a, input logic [15:0] d);
		spk_host_i.wr(a, d);
		settle();
	endtask
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		reset = 1'b1;
		over_temp = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (4) @(posedge core_clk);
		#1;
		reset = 1'b0;
		chk("outs", o, 19'h01C00);
		chk("boost", {13'h0, dc, ac}, 19'h1B);
		for (int i = 0; i < 7; i++) rdchk(adr[i], rst_v[i]);
		for (int i = 0; i < 7; i++) spk_host_i.wr(adr[i], 16'hFFFF);
		for (int i = 0; i < 7; i++) rdchk(adr[i], all_v[i]);
		settle();
		chk("outs", o, 19'h79E7F);
		chk("boost", {13'h0, dc, ac}, 19'h0);
		ws(spk_pkg::OFS_POWER, 16'h0000);
		ws(spk_pkg::OFS_REF_CTRL, 16'h0020);
		ws(spk_pkg::OFS_POP, 16'h0003);
		chk("clamp", o, 19'h00FBF);
		ws(spk_pkg::OFS_REF_CTRL, 16'h0000);
		chk("clamp", o, 19'h00F3E);
		ws(spk_pkg::OFS_BOOST, 16'h002C);
		chk("boost", {13'h0, dc, ac}, 19'h2C);
		ws(spk_pkg::OFS_CLASS, 16'h0000);
		chk("pop", {16'h0, o[11:9]}, 19'h6);
		ws(spk_pkg::OFS_POWER, 16'h0002);
		chk("pop", {16'h0, o[11:9]}, 19'h0);
		ws(spk_pkg::OFS_POWER, 16'h0000);
		ws(spk_pkg::OFS_CLASS, 16'h0040);
		ws(spk_pkg::OFS_POWER, 16'h0002);
		chk("pop", {15'h0, o[17], o[11:9]}, 19'h9);
		ws(spk_pkg::OFS_POWER, 16'h0196);
		over_temp = 1'b1;
		settle();
		chk("thermal", {12'h0, o[18:12]}, 19'h17);
		rdchk(spk_pkg::OFS_POWER, 16'h01D6);
		ws(spk_pkg::OFS_POWER, 16'h0096);
		chk("thermal", {12'h0, o[18:12]}, 19'h3B);
		ws(spk_pkg::OFS_POWER, 16'h0016);
		chk("thermal", {12'h0, o[18:12]}, 19'h38);
		over_temp = 1'b0;
		reset = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		reset = 1'b0;
		chk("outs", o, 19'h01C00);
		chk("boost", {13'h0, dc, ac}, 19'h1B);
		conclude();
	end
endmodule
`default_nettype wire
